/* dv/ldsr_host_model.sv */
// Purpose: host side of the serial register port, mode 0
// Assumes: sclk half period of 5 mclk, above the 4 mclk minimum
// Notes: mosi is inverted on release so a stale level is never read
`timescale 1ns/1ps
`default_nettype none

module ldsr_host_model (
    input wire logic mclk,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    // ------------------------------------------------------------
    // idle pins: clock low, deselected
    // ------------------------------------------------------------
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // change pins just after an mclk edge, never on it
    task automatic ticks(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // ------------------------------------------------------------
    // one 16-bit frame, msb first; byte1 of miso is returned
    // ------------------------------------------------------------
    task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        spi_cs_n = 1'b0;
        ticks(4); // synchronisers see select first
        for (int i = 15; i >= 0; i--) begin
            spi_mosi = tx[i];
            ticks(5);
            spi_sclk = 1'b1;
            if (i < 8) begin
                rx = {rx[6:0], spi_miso};
            end
            ticks(5);
            spi_sclk = 1'b0;
        end
        ticks(2);
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi; // released line shows no stale value
        ticks(8); // gap covers write latency and the 3 mclk minimum
    endtask
endmodule // ldsr_host_model

`default_nettype wire

/* dv/tb_led_dimming_setpoint_regs.sv */
// Purpose: self-checking bench of the dimming set point bank
// Assumes: oscillator pin made from mclk at one tenth of its rate
// Notes: pwm duty is measured over one full 1024-step period
`timescale 1ns/1ps
`default_nettype none

module tb_led_dimming_setpoint_regs;
    import ldsr_pkg::*;
    logic mclk, reset, osc_in, spi_sclk, spi_cs_n, spi_mosi;
    logic spi_miso, spi_miso_oe_n, miso_line, pwm_clk_tick, chan1_dim;
    logic [CODE_W-1:0] chan1_current_code, chan2_current_code;
    logic [CODE_W-1:0] chan1_pwm_width;
    logic [DIV_W-1:0] pwm_clock_divider_select;
    logic [3:0] osc_cnt;
    int miscompares, checks, n, hi;
    logic [6:0] addr_t [7] = '{7'h08, 7'h09, 7'h0A, 7'h0B, 7'h0C,
        7'h0D, 7'h0E};
    logic [7:0] wr_t [7] = '{8'hFD, 8'hA5, 8'hFE, 8'h3C, 8'hFB, 8'h5A,
        8'hF7};
    logic [7:0] rb_t [7] = '{8'h01, 8'hA5, 8'h02, 8'h3C, 8'h03, 8'h5A,
        8'h03};
    int ratio_t [8] = '{7, 8, 10, 12, 16, 24, 49, 98};

    // ------------------------------------------------------------
    // clock, oscillator pin and pulled-up miso wire
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // osc period of 10 mclk keeps tick gaps exact multiples
    always @(posedge mclk) begin
        osc_cnt <= (osc_cnt == 4'h9) ? 4'h0 : osc_cnt + 4'h1;
        osc_in <= (osc_cnt < 4'h5);
    end
    assign miso_line = spi_miso_oe_n ? 1'b1 : spi_miso;

    ldsr_regs_top u_dut (
        .mclk(mclk), .reset(reset), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe_n(spi_miso_oe_n), .osc_in(osc_in),
        .chan1_current_code(chan1_current_code),
        .chan2_current_code(chan2_current_code),
        .chan1_pwm_width(chan1_pwm_width),
        .pwm_clock_divider_select(pwm_clock_divider_select),
        .pwm_clk_tick(pwm_clk_tick), .chan1_dim(chan1_dim)
    );
    ldsr_host_model u_host (
        .mclk(mclk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(miso_line)
    );

    // ------------------------------------------------------------
    // access, compare and closing tasks
    // ------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [6:0] a, input logic [7:0] v);
        logic [7:0] rx;
        u_host.xfer({1'b1, a, v}, rx);
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] rx;
        u_host.xfer({1'b0, a, 8'h00}, rx);
        check("readback", {8'h00, rx}, {8'h00, exp});
    endtask
    // cycles up to the next tick; a lost tick ends the run
    task automatic wait_tick(output int c);
        c = 0;
        do begin
            @(posedge mclk);
            #1;
            c++;
        end while (pwm_clk_tick !== 1'b1 && c < 4000);
        if (c >= 4000) begin
            miscompares++;
            wrap_up();
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        osc_cnt = 4'h0;
        osc_in = 1'b0;
        miscompares = 0;
        checks = 0;
        repeat (3) @(posedge mclk); // three edges flush synchronisers
        #1 reset = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        check("c1 code", {6'h00, chan1_current_code}, 16'h0000);
        check("c2 code", {6'h00, chan2_current_code}, 16'h0000);
        check("p1 width", {6'h00, chan1_pwm_width}, 16'h0000);
        check("div", {13'h0, pwm_clock_divider_select}, 16'h4);
        for (int i = 0; i < 7; i++) begin
            rd_chk(addr_t[i], (i == 4) ? 8'h04 : 8'h00);
        end
        $display("test reset values done");

        // ones written to reserved bits must read back as zero
        for (int i = 0; i < 7; i++) begin
            reg_wr(addr_t[i], wr_t[i]);
        end
        for (int i = 0; i < 7; i++) begin
            rd_chk(addr_t[i], rb_t[i]);
        end
        check("c1 code", {6'h00, chan1_current_code}, 16'h0295);
        check("c2 code", {6'h00, chan2_current_code}, 16'h00F2);
        check("p1 width", {6'h00, chan1_pwm_width}, 16'h035A);
        check("div", {13'h0, pwm_clock_divider_select}, 16'h3);
        $display("test field packing done");

        // neighbours outside the bank must not alias into it
        reg_wr(7'h07, 8'hFF);
        reg_wr(7'h0F, 8'hFF);
        rd_chk(7'h0F, 8'h00);
        rd_chk(7'h09, 8'hA5);
        $display("test unmapped done");

        // every divider code, measured after the change has landed
        for (int s = 0; s < 8; s++) begin
            reg_wr(7'h0C, 8'(s));
            check("div", {13'h0, pwm_clock_divider_select}, 16'(s));
            hi = ratio_t[s] * 10;
            wait_tick(n);
            wait_tick(n);
            check("tick gap", 16'(n), 16'(hi));
            wait_tick(n);
            check("tick gap", 16'(n), 16'(hi));
        end
        $display("test divider done");

        // width 515 at divide-by-7 over one full counter period
        reg_wr(7'h0C, 8'h00);
        reg_wr(7'h0D, 8'h03);
        reg_wr(7'h0E, 8'h02);
        check("p1 width", {6'h00, chan1_pwm_width}, 16'h0203);
        wait_tick(n);
        wait_tick(n);
        hi = 0;
        for (int c = 0; c < 1024 * 70; c++) begin
            @(posedge mclk);
            #1;
            if (chan1_dim === 1'b1) hi++;
        end
        check("dim cycles", 16'(hi), 16'(515 * 70));
        reg_wr(7'h0E, 8'h00);
        reg_wr(7'h0D, 8'h00);
        hi = 0;
        for (int c = 0; c < 500; c++) begin
            @(posedge mclk);
            #1;
            if (chan1_dim !== 1'b0) hi++;
        end
        check("dim at zero", 16'(hi), 16'h0000);
        $display("test pwm duty done");

        // a second reset in mid-run restores the defaults
        reset = 1'b1;
        repeat (3) @(posedge mclk);
        #1 reset = 1'b0;
        @(posedge mclk);
        #1;
        check("c1 code", {6'h00, chan1_current_code}, 16'h0000);
        check("div", {13'h0, pwm_clock_divider_select}, 16'h4);
        rd_chk(7'h09, 8'h00);
        $display("test second reset done");
        wrap_up();
    end
endmodule // tb_led_dimming_setpoint_regs

`default_nettype wire

/* logic/ldsr_pwm_gen.sv */
// Purpose: pwm clock divider and width comparator for one channel
// Assumes: oscillator pin far slower than mclk, sampled as a level
// Notes: a divider change takes effect at once, on the prescale count in progress
`timescale 1ns/1ps
`default_nettype none

module ldsr_pwm_gen (
    input wire logic mclk,
    input wire logic reset,
    input wire logic osc_in,
    input wire logic [ldsr_pkg::DIV_W-1:0] div_sel,
    input wire logic [ldsr_pkg::CODE_W-1:0] width,
    output logic tick_q,
    output logic dim_q
);
    import ldsr_pkg::*;

    logic [1:0] osc_s_q;
    logic osc_prev_q;
    logic [RATIO_W-1:0] pre_q, pre_d;
    logic [CODE_W-1:0] cnt_q, cnt_d;
    logic tick_d, dim_d, osc_rise, wrap;
    logic [RATIO_W-1:0] last;

    assign osc_rise = osc_s_q[1] & ~osc_prev_q;
    assign last = DIV_RATIO[div_sel] - 7'h01;
    // >= so a smaller ratio written mid-count cannot strand the count
    assign wrap = pre_q >= last;

    // prescale oscillator edges, then step the pwm counter
    always_comb begin
        pre_d = pre_q;
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (osc_rise) begin
            if (wrap) begin
                pre_d = '0;
                tick_d = 1'b1;
                cnt_d = cnt_q + 10'h001;
            end else begin
                pre_d = pre_q + 7'h01;
            end
        end
        dim_d = cnt_q < width;
    end

    always_ff @(posedge mclk) begin
        osc_s_q <= {osc_s_q[0], osc_in};
        if (reset) begin
            osc_prev_q <= 1'b0;
            pre_q <= '0;
            cnt_q <= '0;
            tick_q <= 1'b0;
            dim_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_s_q[1];
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            tick_q <= tick_d;
            dim_q <= dim_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence osc_edge_at_wrap;
        osc_rise && (pre_q >= DIV_RATIO[div_sel] - 7'h01);
    endsequence

    tick_ratio_a: assert property (@(posedge mclk) disable iff (reset)
        tick_q |-> $past(osc_rise) && $past(wrap))
        else $error("pwm tick without a full prescale count");
    tick_cause_a: assert property (@(posedge mclk) disable iff (reset)
        osc_edge_at_wrap |=> tick_q && cnt_q == $past(cnt_q) + 10'h001)
        else $error("prescale wrap did not step the counter");
    dim_compare_a: assert property (@(posedge mclk) disable iff (reset)
        ##1 dim_q == ($past(cnt_q) < $past(width)))
        else $error("dim output disagrees with counter compare");

endmodule // ldsr_pwm_gen

`default_nettype wire

/* logic/ldsr_regs_top.sv */
// Purpose: dimming set point register bank with internal pwm generator
// Assumes: host drives the serial port; oscillator arrives on a pin
// Notes: reads of unmapped addresses return zero, writes there vanish
`timescale 1ns/1ps
`default_nettype none

module ldsr_regs_top (
    input wire logic mclk,
    input wire logic reset,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    input wire logic osc_in,
    output logic [ldsr_pkg::CODE_W-1:0] chan1_current_code,
    output logic [ldsr_pkg::CODE_W-1:0] chan2_current_code,
    output logic [ldsr_pkg::CODE_W-1:0] chan1_pwm_width,
    output logic [ldsr_pkg::DIV_W-1:0] pwm_clock_divider_select,
    output logic pwm_clk_tick,
    output logic chan1_dim
);
    import ldsr_pkg::*;

    // ------------------------------------------------------------
    // serial port
    // ------------------------------------------------------------
    ldsr_cmd_s cmd;
    logic cmd_vld;
    logic [7:0] rdata;

    ldsr_spi_slave u_spi (
        .mclk(mclk),
        .reset(reset),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .rdata(rdata),
        .cmd_q(cmd),
        .cmd_vld_q(cmd_vld),
        .miso_q(spi_miso),
        .miso_oe_n_q(spi_miso_oe_n)
    );

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [SPLIT_W-1:0] c1_lo_q, c1_lo_d;
    logic [7:0] c1_hi_q, c1_hi_d;
    logic [SPLIT_W-1:0] c2_lo_q, c2_lo_d;
    logic [7:0] c2_hi_q, c2_hi_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic [7:0] p1_lo_q, p1_lo_d;
    logic [SPLIT_W-1:0] p1_hi_q, p1_hi_d;

    // write decode; only the defined field bits are stored
    always_comb begin
        c1_lo_d = c1_lo_q;
        c1_hi_d = c1_hi_q;
        c2_lo_d = c2_lo_q;
        c2_hi_d = c2_hi_q;
        div_d = div_q;
        p1_lo_d = p1_lo_q;
        p1_hi_d = p1_hi_q;
        if (cmd_vld) begin
            unique case (cmd.addr)
                ADDR_C1_LO: c1_lo_d = cmd.wdata[1:0];
                ADDR_C1_HI: c1_hi_d = cmd.wdata;
                ADDR_C2_LO: c2_lo_d = cmd.wdata[1:0];
                ADDR_C2_HI: c2_hi_d = cmd.wdata;
                ADDR_DIV: div_d = cmd.wdata[2:0];
                ADDR_P1_LO: p1_lo_d = cmd.wdata;
                ADDR_P1_HI: p1_hi_d = cmd.wdata[1:0];
                default: ; // unmapped: write dropped
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            c1_lo_q <= RST_PAIR;
            c1_hi_q <= RST_BYTE;
            c2_lo_q <= RST_PAIR;
            c2_hi_q <= RST_BYTE;
            div_q <= RST_DIV;
            p1_lo_q <= RST_BYTE;
            p1_hi_q <= RST_PAIR;
        end else begin
            c1_lo_q <= c1_lo_d;
            c1_hi_q <= c1_hi_d;
            c2_lo_q <= c2_lo_d;
            c2_hi_q <= c2_hi_d;
            div_q <= div_d;
            p1_lo_q <= p1_lo_d;
            p1_hi_q <= p1_hi_d;
        end
    end

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    // reserved bits pad with zero; read is side effect free
    always_comb begin
        unique case (cmd.addr)
            ADDR_C1_LO: rdata = {6'h00, c1_lo_q};
            ADDR_C1_HI: rdata = c1_hi_q;
            ADDR_C2_LO: rdata = {6'h00, c2_lo_q};
            ADDR_C2_HI: rdata = c2_hi_q;
            ADDR_DIV: rdata = {5'h00, div_q};
            ADDR_P1_LO: rdata = p1_lo_q;
            ADDR_P1_HI: rdata = {6'h00, p1_hi_q};
            default: rdata = UNMAPPED_DATA;
        endcase
    end

    // ------------------------------------------------------------
    // set point outputs, all straight from the storage flops
    // ------------------------------------------------------------
    assign chan1_current_code = {c1_hi_q, c1_lo_q};
    assign chan2_current_code = {c2_hi_q, c2_lo_q};
    assign chan1_pwm_width = {p1_hi_q, p1_lo_q};
    assign pwm_clock_divider_select = div_q;

    // ------------------------------------------------------------
    // internal pwm generator for channel 1
    // ------------------------------------------------------------
    ldsr_pwm_gen u_pwm (
        .mclk(mclk),
        .reset(reset),
        .osc_in(osc_in),
        .div_sel(div_q),
        .width(chan1_pwm_width),
        .tick_q(pwm_clk_tick),
        .dim_q(chan1_dim)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence wr_to(logic [6:0] a);
        cmd_vld && cmd.addr == a;
    endsequence

    reset_values_a: assert property (@(posedge mclk)
        $past(reset) |-> chan1_current_code == 10'h000
            && chan2_current_code == 10'h000
            && chan1_pwm_width == 10'h000 && div_q == 3'h4)
        else $error("set points not at reset value after reset");
    c1_low_write_a: assert property (@(posedge mclk) disable iff (reset)
        wr_to(7'h08) |=> chan1_current_code[1:0] == $past(cmd.wdata[1:0])
            && chan1_current_code[9:2] == $past(chan1_current_code[9:2]))
        else $error("chan1 low current write misplaced");
    c1_high_write_a: assert property (@(posedge mclk) disable iff (reset)
        wr_to(7'h09) |=> chan1_current_code[9:2] == $past(cmd.wdata)
            && chan1_current_code[1:0] == $past(chan1_current_code[1:0]))
        else $error("chan1 high current write misplaced");
    c2_split_a: assert property (@(posedge mclk) disable iff (reset)
        wr_to(7'h0B) |=>
            chan2_current_code == {$past(cmd.wdata), $past(c2_lo_q)})
        else $error("chan2 current code assembled wrongly");
    p1_width_a: assert property (@(posedge mclk) disable iff (reset)
        wr_to(7'h0E) |=> chan1_pwm_width[9:8] == $past(cmd.wdata[1:0])
            && chan1_pwm_width[7:0] == $past(chan1_pwm_width[7:0]))
        else $error("chan1 width high write misplaced");
    div_field_a: assert property (@(posedge mclk) disable iff (reset)
        wr_to(7'h0C) |=> div_q == $past(cmd.wdata[2:0]))
        else $error("divider select not taken from bits 2-0");
    reserved_zero_a: assert property (@(posedge mclk) disable iff (reset)
        (cmd.addr == 7'h0C) |-> rdata[7:3] == 5'h00
            && rdata[2:0] == div_q)
        else $error("reserved divider bits read nonzero");
    unmapped_hold_a: assert property (@(posedge mclk) disable iff (reset)
        cmd_vld && (cmd.addr < 7'h08 || cmd.addr > 7'h0E) |=>
            $stable(chan1_current_code) && $stable(chan2_current_code)
            && $stable(chan1_pwm_width) && $stable(div_q))
        else $error("unmapped write changed a set point");

endmodule // ldsr_regs_top

`default_nettype wire

/* logic/ldsr_spi_slave.sv */
// Purpose: serial register port, mode 0, 16-bit frames
// Assumes: sclk half period spans at least four mclk periods
// Notes: read data shifts out during the second byte of any frame
`timescale 1ns/1ps
`default_nettype none

module ldsr_spi_slave (
    input wire logic mclk,
    input wire logic reset,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic [7:0] rdata,
    output var ldsr_pkg::ldsr_cmd_s cmd_q,
    output logic cmd_vld_q,
    output logic miso_q,
    output logic miso_oe_n_q
);
    import ldsr_pkg::*;

    logic [1:0] sclk_s_q, cs_s_q, mosi_s_q;
    logic sclk_prev_q, load_q, load_d;
    logic [4:0] bitcnt_q, bitcnt_d;
    logic [15:0] shift_q, shift_d;
    logic [7:0] tx_q, tx_d;
    ldsr_cmd_s cmd_d;
    logic cmd_vld_d, miso_d;
    logic rise, fall;

    // pins cross into mclk through two flops; only the second stage is read
    assign rise = sclk_s_q[1] & ~sclk_prev_q;
    assign fall = ~sclk_s_q[1] & sclk_prev_q;

    // frame sequencing: shift in on rise, shift out on fall
    always_comb begin
        bitcnt_d = bitcnt_q;
        shift_d = shift_q;
        tx_d = tx_q;
        cmd_d = cmd_q;
        cmd_vld_d = 1'b0;
        load_d = 1'b0;
        miso_d = miso_q;
        if (cs_s_q[1]) begin
            bitcnt_d = 5'h00;
        end else if (rise) begin
            shift_d = {shift_q[14:0], mosi_s_q[1]};
            bitcnt_d = bitcnt_q + 5'h01;
            if (bitcnt_d == HDR_BITS) begin
                cmd_d.addr = shift_d[6:0];
                load_d = 1'b1;
            end
            if (bitcnt_d == FRAME_BITS) begin
                cmd_d.wr = shift_d[WR_FLAG_POS];
                cmd_d.wdata = shift_d[7:0];
                cmd_vld_d = shift_d[WR_FLAG_POS];
                bitcnt_d = 5'h00;
            end
        end else if (fall && bitcnt_q >= HDR_BITS) begin
            miso_d = tx_q[7];
            tx_d = {tx_q[6:0], 1'b0};
        end
        // address settled one cycle earlier, so the mux output is stable
        if (load_q) begin
            tx_d = rdata;
        end
    end

    always_ff @(posedge mclk) begin
        sclk_s_q <= {sclk_s_q[0], spi_sclk};
        cs_s_q <= {cs_s_q[0], spi_cs_n};
        mosi_s_q <= {mosi_s_q[0], spi_mosi};
        if (reset) begin
            sclk_prev_q <= 1'b0;
            bitcnt_q <= 5'h00;
            shift_q <= 16'h0000;
            tx_q <= 8'h00;
            load_q <= 1'b0;
            cmd_q <= '0;
            cmd_vld_q <= 1'b0;
            miso_q <= 1'b0;
            miso_oe_n_q <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_s_q[1];
            bitcnt_q <= bitcnt_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            load_q <= load_d;
            cmd_q <= cmd_d;
            cmd_vld_q <= cmd_vld_d;
            miso_q <= miso_d;
            miso_oe_n_q <= cs_s_q[1]; // released while deselected
        end
    end

endmodule // ldsr_spi_slave

`default_nettype wire

/* pkg/ldsr_pkg.sv */
// Purpose: shared constants and types of the led dimming set point bank
// Assumes: one clock mclk at 100 MHz, synchronous active high reset
// Notes: registers sit at byte addresses on the serial register port

package ldsr_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_C1_LO = 7'h08;
    localparam logic [6:0] ADDR_C1_HI = 7'h09;
    localparam logic [6:0] ADDR_C2_LO = 7'h0A;
    localparam logic [6:0] ADDR_C2_HI = 7'h0B;
    localparam logic [6:0] ADDR_DIV = 7'h0C;
    localparam logic [6:0] ADDR_P1_LO = 7'h0D;
    localparam logic [6:0] ADDR_P1_HI = 7'h0E;

    // ------------------------------------------------------------
    // field widths and reset values
    // ------------------------------------------------------------
    localparam int CODE_W = 10;
    localparam int SPLIT_W = 2;
    localparam int DIV_W = 3;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_PAIR = 2'h0;
    localparam logic [2:0] RST_DIV = 3'h4;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // ------------------------------------------------------------
    // pwm clock divider
    // ------------------------------------------------------------
    localparam int OSC_FREQ_KHZ = 10800;
    localparam int RATIO_W = 7;
    localparam logic [6:0] DIV_RATIO [8] = '{
        7'h07, 7'h08, 7'h0A, 7'h0C, 7'h10, 7'h18, 7'h31, 7'h62
    };

    // ------------------------------------------------------------
    // serial frame: first byte write flag and address, second data
    // ------------------------------------------------------------
    localparam logic [4:0] HDR_BITS = 5'h08;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam int WR_FLAG_POS = 15;

    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } ldsr_cmd_s;

endpackage
